// ---- spn_map.svh ----
`ifndef SPN_MAP_SVH
`define SPN_MAP_SVH
// What this block does
// - 16-bit instruction: read flag, length, 13-bit address
// - Length code 0..2 gives 1..3 bytes, 3 streams
// - Master sends upper three address bits zero
// - Config byte upper nibble mirrors lower nibble
// - Config bits 2/6 select LSB first immediately; the code reads bit 2 only
// - MSB first: MSB leads, address decrements
// - LSB first: LSB leads, address increments
// - Incrementing stream stops after top address
// - Decrement past zero visits top, then stops
// - Address walks every address, nothing skipped
// - Device holds 512-byte nonvolatile store
// - Busy store blocks access except busy read
// - Busy bit set at start, cleared at end
// - Slave address acknowledge only when store idle
// - Busy flag selectable onto status pin
// - Store written only by internal copy
// - Master sets write enable, save, commit
// - Copy registers to store, clear save request
// - Master clears write enable after busy drops
// - Error bit reads one on failed save
// - Master sets calibrate bit before saving
// - Commit copies buffered writes to active
// - Sample on rising sclk, read on falling

// Link framing
`define SPN_INSTR_BITS     16
`define SPN_ADDR_BITS      13
`define SPN_LEN_STREAM     2'h3
// Device register map
`define SPN_CFG_ADDR       13'h0000
`define SPN_OSC_CAL_ADDR   13'h0018
`define SPN_TOP_ADDR       13'h0232
`define SPN_BUSY_ADDR      13'h0b00
`define SPN_ERR_ADDR       13'h0b01
`define SPN_WREN_ADDR      13'h0b02
`define SPN_SAVE_ADDR      13'h0b03
`define SPN_CFG_LSB_LO     2
`define SPN_CFG_LSB_HI     6
`define SPN_CFG_RST        8'h18
`define SPN_COMMIT_BIT     0
`define SPN_NVM_BYTES      512
// Timing
`define SPN_CORE_PERIOD_NS 50
`define SPN_LINK_PERIOD_NS 400
`define SPN_SCLK_HALF      ((`SPN_LINK_PERIOD_NS / `SPN_CORE_PERIOD_NS) / 2)
// Host controller registers
`define SPN_HC_CTRL        8'h00
`define SPN_HC_ADDR        8'h04
`define SPN_HC_TX          8'h08
`define SPN_HC_RX          8'h0c
`define SPN_HC_STAT        8'h10
`define SPN_HC_GO          0
`define SPN_HC_RW          1
`define SPN_HC_LSB         2
`define SPN_HC_LEN_LO      3
`endif

// ---- spn_pkg.sv ----
package spn_pkg;
    typedef logic [12:0] spn_addr_t;
    typedef enum logic [1:0] {SPN_D_INSTR, SPN_D_DATA, SPN_D_HALT} spn_dev_state_t;
    typedef enum logic [1:0] {SPN_H_IDLE, SPN_H_LOW, SPN_H_HIGH, SPN_H_GAP} spn_host_state_t;
endpackage

// ---- spn_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface spn_link_if;
    logic sclk;
    logic cs_n;
    logic sdio_m_o;
    logic sdio_m_oe_n;
    logic sdio_s_o;
    logic sdio_s_oe_n;
    logic sdio;
    // Resolved shared data wire; pulled low when nobody drives
    assign sdio = !sdio_s_oe_n ? sdio_s_o : (!sdio_m_oe_n ? sdio_m_o : 1'b0);
    modport dev  (input sclk, cs_n, sdio, output sdio_s_o, sdio_s_oe_n);
    modport host (input sdio, output sclk, cs_n, sdio_m_o, sdio_m_oe_n);
endinterface
`default_nettype wire

// ---- spn_dev_end.sv ----
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "spn_map.svh"
module spn_dev_end
    import spn_pkg::*;
#(
    parameter int NVM_BYTES = `SPN_NVM_BYTES
)(
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    spn_link_if.dev         link,
    input  wire logic       status_sel_busy,
    input  wire logic [8:0] nvm_rd_addr,
    output logic            status_pin,
    output logic            i2c_addr_ack,
    output logic            nvm_busy,
    output logic            commit_pulse,
    output logic [7:0]      nvm_rd_data
);
    localparam int TOP = 16'h0232;
    // The master sends the top three address bits as zero, so the store
    // registers decode on the low ten bits only
    localparam logic [9:0] BUSY_A = 10'(`SPN_BUSY_ADDR);
    localparam logic [9:0] ERR_A  = 10'(`SPN_ERR_ADDR);
    localparam logic [9:0] WREN_A = 10'(`SPN_WREN_ADDR);
    localparam logic [9:0] SAVE_A = 10'(`SPN_SAVE_ADDR);

    logic [7:0]     buf_mem [0:TOP];
    logic [7:0]     act_mem [0:TOP];
    logic [7:0]     nvm_mem [0:NVM_BYTES-1];
    logic           sclk_s1_q, sclk_s2_q, sclk_s3_q;
    logic           cs_s1_q, cs_s2_q;
    logic           sd_s1_q, sd_s2_q;
    logic           rise, fall, lsb, byte_done, wr_en, commit, last_byte;
    logic [15:0]    sh_d;
    logic [7:0]     rx_byte;
    spn_dev_state_t st_q;
    logic [15:0]    sh_q;
    logic [3:0]     cnt_q;
    logic           rw_q, stream_q, wrap_q;
    logic [1:0]     left_q;
    spn_addr_t      addr_q;
    logic [7:0]     tx_q;
    logic [7:0]     cfg_q;
    logic           we_q, save_q, err_q, busy_q;
    logic [8:0]     ptr_q;

    // Readback; while the store is busy only the busy flag answers
    function automatic logic [7:0] rd_byte(input spn_addr_t a);
        if (busy_q && a[9:0] != BUSY_A) return 8'h00;
        if (a == `SPN_CFG_ADDR) return cfg_q; // Live port config
        if (a <= `SPN_TOP_ADDR) return buf_mem[a[9:0]];
        unique case (a[9:0])
            BUSY_A:  return {7'h00, busy_q};
            ERR_A:   return {7'h00, err_q};
            WREN_A:  return {7'h00, we_q};
            SAVE_A:  return {7'h00, save_q};
            default: return 8'h00;
        endcase
    endfunction

    // Next address: up in LSB-first, down with wrap to top otherwise
    function automatic spn_addr_t next_addr(input spn_addr_t a, input logic up);
        if (up) return a + 13'h0001;
        if (a == 13'h0000) return `SPN_TOP_ADDR;
        return a - 13'h0001;
    endfunction

    // Two flops on every pin before logic looks at it; third for edges
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_s1_q <= 1'b0;
            sclk_s2_q <= 1'b0;
            sclk_s3_q <= 1'b0;
            cs_s1_q   <= 1'b1;
            cs_s2_q   <= 1'b1;
            sd_s1_q   <= 1'b0;
            sd_s2_q   <= 1'b0;
        end else begin
            sclk_s1_q <= link.sclk;
            sclk_s2_q <= sclk_s1_q;
            sclk_s3_q <= sclk_s2_q;
            cs_s1_q   <= link.cs_n;
            cs_s2_q   <= cs_s1_q;
            sd_s1_q   <= link.sdio;
            sd_s2_q   <= sd_s1_q;
        end
    end

    // Edge detect and shared shift decode
    assign rise      = sclk_s2_q & ~sclk_s3_q & ~cs_s2_q;
    assign fall      = ~sclk_s2_q & sclk_s3_q & ~cs_s2_q;
    assign lsb       = cfg_q[`SPN_CFG_LSB_LO];
    assign sh_d      = lsb ? {sd_s2_q, sh_q[15:1]} : {sh_q[14:0], sd_s2_q};
    assign rx_byte   = lsb ? sh_d[15:8] : sh_d[7:0];
    assign byte_done = (st_q == SPN_D_DATA) && rise && (cnt_q == 4'h7);
    assign last_byte = stream_q ? (lsb ? (addr_q == `SPN_TOP_ADDR) : wrap_q)
                                : (left_q == 2'h0);
    assign wr_en     = byte_done && !rw_q && !busy_q;
    assign commit    = wr_en && (addr_q == `SPN_TOP_ADDR) && rx_byte[`SPN_COMMIT_BIT];

    // Instruction and data sequencing
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q     <= SPN_D_INSTR;
            sh_q     <= 16'h0000;
            cnt_q    <= 4'h0;
            rw_q     <= 1'b0;
            stream_q <= 1'b0;
            wrap_q   <= 1'b0;
            left_q   <= 2'h0;
            addr_q   <= 13'h0000;
            tx_q     <= 8'h00;
        end else if (cs_s2_q) begin
            st_q  <= SPN_D_INSTR; // Frame over; a partial byte is dropped
            cnt_q <= 4'h0;
        end else if (rise) begin
            sh_q  <= sh_d;
            cnt_q <= cnt_q + 4'h1;
            if (st_q == SPN_D_INSTR && cnt_q == 4'hf) begin
                rw_q     <= sh_d[15];
                left_q   <= sh_d[14:13];
                stream_q <= (sh_d[14:13] == `SPN_LEN_STREAM);
                addr_q   <= sh_d[12:0];
                wrap_q   <= 1'b0;
                tx_q     <= rd_byte(sh_d[12:0]);
                st_q     <= SPN_D_DATA;
                cnt_q    <= 4'h0;
            end else if (byte_done) begin
                cnt_q <= 4'h0;
                if (last_byte) begin
                    st_q <= SPN_D_HALT;
                end else begin
                    addr_q <= next_addr(addr_q, lsb);
                    tx_q   <= rd_byte(next_addr(addr_q, lsb));
                    left_q <= left_q - 2'h1;
                    if (!lsb && addr_q == 13'h0000) begin
                        wrap_q <= 1'b1;
                    end
                end
            end
        end
    end

    // Read data leaves on falling edges so the master takes it there
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            link.sdio_s_o    <= 1'b0;
            link.sdio_s_oe_n <= 1'b1;
        end else if (cs_s2_q || st_q != SPN_D_DATA || !rw_q) begin
            link.sdio_s_oe_n <= 1'b1;
        end else if (fall) begin
            link.sdio_s_oe_n <= 1'b0;
            link.sdio_s_o    <= tx_q[lsb ? cnt_q[2:0] : 3'h7 - cnt_q[2:0]];
        end
    end

    // Buffer writes, with the commit bit kept self-clearing
    always_ff @(posedge core_clk) begin
        if (wr_en && addr_q <= `SPN_TOP_ADDR) begin
            buf_mem[addr_q[9:0]] <= (addr_q == `SPN_TOP_ADDR) ? (rx_byte & 8'hfe) : rx_byte;
        end
    end

    // Whole buffer goes live in one edge, so changes land together
    always_ff @(posedge core_clk) begin
        if (commit) begin
            act_mem <= buf_mem;
        end
    end

    // Port config acts at once, not at commit; master keeps it mirrored
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_q <= `SPN_CFG_RST;
        end else if (wr_en && addr_q == `SPN_CFG_ADDR) begin
            cfg_q <= rx_byte;
        end
    end

    // Store control: enable, save request, busy, error
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            we_q   <= 1'b0;
            save_q <= 1'b0;
            err_q  <= 1'b0;
            busy_q <= 1'b0;
            ptr_q  <= 9'h000;
        end else begin
            if (wr_en && addr_q[9:0] == WREN_A) begin
                we_q <= rx_byte[0];
            end
            if (wr_en && addr_q[9:0] == SAVE_A) begin
                save_q <= rx_byte[0];
            end
            if (commit && save_q) begin
                busy_q <= we_q;
                err_q  <= !we_q; // Save without enable fails
                ptr_q  <= 9'h000;
            end else if (busy_q) begin
                ptr_q <= ptr_q + 9'h001;
                if (ptr_q == 9'(NVM_BYTES - 1)) begin
                    busy_q <= 1'b0;
                    save_q <= 1'b0;
                    err_q  <= 1'b0;
                end
            end
        end
    end

    // Only the internal copy writes the store; one byte a cycle
    always_ff @(posedge core_clk) begin
        if (busy_q) begin
            nvm_mem[ptr_q] <= act_mem[ptr_q];
        end
    end

    // Store readback for inspection of the saved image
    always_ff @(posedge core_clk) begin
        nvm_rd_data <= nvm_mem[nvm_rd_addr];
    end

    // Status pin source, slave address answer, busy and commit outputs
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            status_pin   <= 1'b0;
            i2c_addr_ack <= 1'b1;
            nvm_busy     <= 1'b0;
            commit_pulse <= 1'b0;
        end else begin
            status_pin   <= status_sel_busy ? busy_q : err_q;
            i2c_addr_ack <= !busy_q;
            nvm_busy     <= busy_q;
            commit_pulse <= commit;
        end
    end
endmodule // spn_dev_end
`default_nettype wire

// ---- spn_host_end.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "spn_map.svh"
module spn_host_end
    import spn_pkg::*;
#(
    parameter int HALF = `SPN_SCLK_HALF
)(
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    spn_link_if.host         link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    spn_host_state_t st_q;
    logic            rw_q, lsb_q, busy_q, sd_s1_q, sd_s2_q;
    logic [1:0]      len_q;
    spn_addr_t       addr_q;
    logic [31:0]     tx_q, rx_q;
    logic [5:0]      idx_q, nbits;
    logic [3:0]      div_q;
    logic            go, div_done, rd_phase;
    logic [5:0]      doff;

    assign go       = psel && penable && pready && pwrite && paddr == `SPN_HC_CTRL
                      && pwdata[`SPN_HC_GO] && !busy_q;
    assign nbits    = 6'd16 + {1'b0, len_q, 3'h0} + 6'd8; // Streams send four
    assign div_done = (div_q == 4'(HALF - 1));
    assign doff     = idx_q - 6'd16;
    assign rd_phase = rw_q && (idx_q >= 6'd16);

    // Bit on the wire for a frame position, in the chosen order
    function automatic logic bit_at(input logic [5:0] i);
        logic [15:0] ins;
        logic [5:0]  o;
        logic [7:0]  b;
        ins = {rw_q, len_q, 3'h0, addr_q[9:0]};
        o   = i - 6'd16;
        b   = tx_q[{o[4:3], 3'h0} +: 8];
        if (i < 6'd16) return lsb_q ? ins[i[3:0]] : ins[4'hf - i[3:0]];
        return lsb_q ? b[o[2:0]] : b[3'h7 - o[2:0]];
    endfunction

    // Read data pin synchroniser
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sd_s1_q <= 1'b0;
            sd_s2_q <= 1'b0;
        end else begin
            sd_s1_q <= link.sdio;
            sd_s2_q <= sd_s1_q;
        end
    end

    // APB slave: no wait state, yet read data comes from a flop
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            if (psel && !penable) begin
                unique case (paddr)
                    `SPN_HC_CTRL: prdata <= {27'h000_0000, len_q, lsb_q, rw_q, busy_q};
                    `SPN_HC_ADDR: prdata <= {19'h0_0000, addr_q};
                    `SPN_HC_TX:   prdata <= tx_q;
                    `SPN_HC_RX:   prdata <= rx_q;
                    `SPN_HC_STAT: prdata <= {31'h0000_0000, busy_q};
                    default:      prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Order registers written by software
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rw_q   <= 1'b0;
            lsb_q  <= 1'b0;
            len_q  <= 2'h0;
            addr_q <= 13'h0000;
            tx_q   <= 32'h0000_0000;
        end else if (psel && penable && pready && pwrite && !busy_q) begin
            unique case (paddr)
                `SPN_HC_CTRL: begin
                    rw_q  <= pwdata[`SPN_HC_RW];
                    lsb_q <= pwdata[`SPN_HC_LSB];
                    len_q <= pwdata[`SPN_HC_LEN_LO +: 2];
                end
                `SPN_HC_ADDR: addr_q <= pwdata[12:0];
                `SPN_HC_TX:   tx_q <= pwdata;
                default: ;
            endcase
        end
    end

    // Frame engine: drive on low phase, device samples rising edge
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q             <= SPN_H_IDLE;
            busy_q           <= 1'b0;
            idx_q            <= 6'd0;
            div_q            <= 4'h0;
            rx_q             <= 32'h0000_0000;
            link.sclk        <= 1'b0;
            link.cs_n        <= 1'b1;
            link.sdio_m_o    <= 1'b0;
            link.sdio_m_oe_n <= 1'b1;
        end else begin
            div_q <= div_done ? 4'h0 : div_q + 4'h1;
            unique case (st_q)
                SPN_H_IDLE: begin
                    div_q <= 4'h0;
                    if (go) begin
                        busy_q           <= 1'b1;
                        idx_q            <= 6'd0;
                        link.cs_n        <= 1'b0;
                        link.sdio_m_oe_n <= 1'b0;
                        st_q             <= SPN_H_LOW;
                    end
                end
                SPN_H_LOW: begin
                    // Bit goes out a cycle after go or the fall, so order bits
                    // written together with go are already in place
                    if (div_q == 4'h0) begin
                        link.sdio_m_o <= bit_at(idx_q);
                    end
                    if (div_done) begin
                        link.sclk <= 1'b1;
                        st_q      <= SPN_H_HIGH;
                    end
                end
                SPN_H_HIGH: if (div_done) begin
                    link.sclk <= 1'b0;
                    if (rd_phase) begin
                        // Taken as the falling edge is made
                        rx_q[{doff[4:3], (lsb_q ? doff[2:0] : 3'h7 - doff[2:0])}] <= sd_s2_q;
                    end
                    idx_q <= idx_q + 6'd1;
                    if (idx_q == nbits - 6'd1) begin
                        link.sdio_m_oe_n <= 1'b1;
                        st_q             <= SPN_H_GAP;
                    end else begin
                        link.sdio_m_oe_n <= rw_q && (idx_q + 6'd1 >= 6'd16);
                        st_q             <= SPN_H_LOW;
                    end
                end
                SPN_H_GAP: if (div_done) begin
                    link.cs_n <= 1'b1;
                    busy_q    <= 1'b0;
                    st_q      <= SPN_H_IDLE;
                end
            endcase
        end
    end
endmodule // spn_host_end
`default_nettype wire

// ---- spn_link_props.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "spn_map.svh"
module spn_link_props #(
    parameter int NVM_BYTES = `SPN_NVM_BYTES
)(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdio_m_o,
    input wire logic sdio_m_oe_n,
    input wire logic sdio_s_o,
    input wire logic sdio_s_oe_n,
    input wire logic nvm_busy,
    input wire logic commit_pulse,
    input wire logic status_pin,
    input wire logic i2c_addr_ack,
    input wire logic status_sel_busy
);
    logic [15:0] busy_cnt_q;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    // Length of the busy span, so the copy length can be judged at its end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_cnt_q <= 16'h0;
        end else if (!nvm_busy) begin
            busy_cnt_q <= 16'h0;
        end else begin
            busy_cnt_q <= busy_cnt_q + 16'h1;
        end
    end

    // Shared data wire and link clock discipline
    a_no_wire_fight: assert property (!(!sdio_m_oe_n && !sdio_s_oe_n))
        else $error("both ends drive the data wire");
    a_sclk_idle_low: assert property (cs_n |-> !sclk)
        else $error("link clock not low outside a frame");
    a_host_bit_stable: assert property ($rose(sclk) && !sdio_m_oe_n |-> $stable(sdio_m_o))
        else $error("host data moved at the sampling rise");
    a_dev_bit_stable: assert property (
        $fell(sclk) && !sdio_s_oe_n && $past(!sdio_s_oe_n) |-> $stable(sdio_s_o))
        else $error("device data moved at the sampling fall");
    a_dev_quiet_idle: assert property (cs_n [*6] |-> sdio_s_oe_n)
        else $error("device drives with the frame closed");
    // Store controller
    a_commit_single: assert property (commit_pulse |=> !commit_pulse)
        else $error("commit pulse longer than one cycle");
    a_busy_cause: assert property ($rose(nvm_busy) |-> $past(commit_pulse))
        else $error("store busy without a commit");
    a_busy_span: assert property ($fell(nvm_busy) |-> busy_cnt_q == NVM_BYTES)
        else $error("store busy span has the wrong length");
    a_ack_vs_busy: assert property ($stable(nvm_busy) |-> i2c_addr_ack == !nvm_busy)
        else $error("address acknowledge disagrees with busy");
    a_pin_busy: assert property (
        status_sel_busy && $stable(status_sel_busy) && $stable(nvm_busy)
        |-> status_pin == nvm_busy)
        else $error("status pin does not follow busy");

    c_save_run: cover property ($rose(nvm_busy));
    c_commit: cover property (commit_pulse);
    c_dev_read: cover property ($fell(sdio_s_oe_n));
endmodule // spn_link_props
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "spn_map.svh"
module tb_top;
    logic        core_clk;
    logic        arst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        status_sel_busy;
    logic [8:0]  nvm_rd_addr;
    logic        status_pin;
    logic        i2c_addr_ack;
    logic        nvm_busy;
    logic        commit_pulse;
    logic [7:0]  nvm_rd_data;
    int          err_count;
    int          check_count;
    int          commit_cnt;
    int          n;
    logic [31:0] rx;

    spn_link_if link ();
    spn_dev_end #(.NVM_BYTES(`SPN_NVM_BYTES)) i_spn_dev_end (
        .core_clk(core_clk), .arst_n(arst_n), .link(link),
        .status_sel_busy(status_sel_busy), .nvm_rd_addr(nvm_rd_addr),
        .status_pin(status_pin), .i2c_addr_ack(i2c_addr_ack), .nvm_busy(nvm_busy),
        .commit_pulse(commit_pulse), .nvm_rd_data(nvm_rd_data));
    spn_host_end #(.HALF(`SPN_SCLK_HALF)) i_spn_host_end (
        .core_clk(core_clk), .arst_n(arst_n), .link(link), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    spn_link_props #(.NVM_BYTES(`SPN_NVM_BYTES)) i_spn_link_props (
        .core_clk(core_clk), .arst_n(arst_n), .sclk(link.sclk), .cs_n(link.cs_n),
        .sdio_m_o(link.sdio_m_o), .sdio_m_oe_n(link.sdio_m_oe_n),
        .sdio_s_o(link.sdio_s_o), .sdio_s_oe_n(link.sdio_s_oe_n),
        .nvm_busy(nvm_busy), .commit_pulse(commit_pulse), .status_pin(status_pin),
        .i2c_addr_ack(i2c_addr_ack), .status_sel_busy(status_sel_busy));

    // Core clock, 50 ns period
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Counts commits seen at the device's user side
    always @(posedge core_clk) begin
        if (commit_pulse === 1'b1) commit_cnt++;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // One link frame through the host's registers; waits for the host to go idle
    task automatic xfer(input logic rw, input logic lsb, input logic [1:0] len,
                        input logic [12:0] a, input logic [31:0] tx, output logic [31:0] q);
        logic [31:0] s;
        int k;
        apb(1'b1, `SPN_HC_ADDR, {19'h0, a}, s);
        apb(1'b1, `SPN_HC_TX, tx, s);
        apb(1'b1, `SPN_HC_CTRL, {27'h0, len, lsb, rw, 1'b1}, s);
        k = 0;
        s = 32'h1;
        while (s[0] !== 1'b0 && k < 300) begin
            apb(1'b0, `SPN_HC_STAT, 32'h0, s);
            k++;
        end
        chk("host idle", 32'h0, {31'h0, s[0]});
        q = 32'h0;
        if (rw) apb(1'b0, `SPN_HC_RX, 32'h0, q);
    endtask

    // Hang guard, well beyond the expected run of some five thousand cycles
    initial begin
        repeat (40000) @(posedge core_clk);
        err_count++;
        finish_test();
    end

    initial begin
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        status_sel_busy = 1'b0;
        nvm_rd_addr = 9'h000;
        err_count = 0;
        check_count = 0;
        commit_cnt = 0;
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        // Two bytes, MSB first: first byte at the given address, then one below
        xfer(1'b0, 1'b0, 2'd1, 13'h0019, 32'h0000_A55A, rx);
        xfer(1'b1, 1'b0, 2'd1, 13'h0019, 32'h0, rx);
        chk("msb pair", 32'h0000_A55A, rx & 32'h0000_FFFF);
        // Decrementing stream wraps from zero to the top address and stops
        xfer(1'b0, 1'b0, 2'd2, 13'h0001, 32'h0000_183C, rx);
        xfer(1'b1, 1'b0, 2'd3, 13'h0001, 32'h0, rx);
        chk("msb stream", 32'h0000_183C, rx & 32'hFF00_FFFF);
        $display("test msb_order done");
        // Mirrored config byte turns on LSB first at once
        xfer(1'b0, 1'b0, 2'd0, 13'h0000, 32'h0000_007E, rx);
        xfer(1'b0, 1'b1, 2'd3, 13'h0230, 32'h7700_2211, rx);
        xfer(1'b1, 1'b1, 2'd3, 13'h0230, 32'h0, rx);
        chk("lsb stream", 32'h0000_2211, rx & 32'hFF00_FFFF);
        xfer(1'b0, 1'b1, 2'd0, 13'h0000, 32'h0000_0018, rx);
        xfer(1'b1, 1'b0, 2'd0, 13'h0000, 32'h0, rx);
        chk("cfg msb", 32'h0000_0018, rx & 32'h0000_00FF);
        $display("test lsb_order done");
        // Save requested without write enable reports an error
        xfer(1'b0, 1'b0, 2'd0, 13'h0B03, 32'h1, rx);
        xfer(1'b0, 1'b0, 2'd0, 13'h0232, 32'h1, rx);
        xfer(1'b1, 1'b0, 2'd0, 13'h0B01, 32'h0, rx);
        chk("err bit", 32'h1, rx & 32'h1);
        chk("status err", 32'h1, {31'h0, status_pin});
        chk("commits", 32'h1, commit_cnt);
        $display("test save_refused done");
        // Full save sequence; access blocked while the copy runs
        status_sel_busy <= 1'b1;
        xfer(1'b0, 1'b0, 2'd0, 13'h0B02, 32'h1, rx);
        xfer(1'b0, 1'b0, 2'd0, 13'h0B03, 32'h1, rx);
        xfer(1'b0, 1'b0, 2'd0, 13'h0232, 32'h1, rx);
        chk("busy", 32'h1, {31'h0, nvm_busy});
        chk("status busy", 32'h1, {31'h0, status_pin});
        chk("ack in save", 32'h0, {31'h0, i2c_addr_ack});
        xfer(1'b1, 1'b0, 2'd0, 13'h0B00, 32'h0, rx);
        chk("busy reg", 32'h1, rx & 32'h1);
        xfer(1'b0, 1'b0, 2'd0, 13'h0019, 32'h0000_00FF, rx);
        n = 0;
        while (nvm_busy !== 1'b0 && n < 1000) begin
            @(posedge core_clk);
            n++;
        end
        chk("busy end", 32'h0, {31'h0, nvm_busy});
        @(posedge core_clk);
        chk("ack idle", 32'h1, {31'h0, i2c_addr_ack});
        xfer(1'b1, 1'b0, 2'd0, 13'h0019, 32'h0, rx);
        chk("blocked write", 32'h5A, rx & 32'h0000_00FF);
        xfer(1'b1, 1'b0, 2'd0, 13'h0B03, 32'h0, rx);
        chk("save cleared", 32'h0, rx & 32'h1);
        xfer(1'b1, 1'b0, 2'd0, 13'h0B01, 32'h0, rx);
        chk("err cleared", 32'h0, rx & 32'h1);
        xfer(1'b0, 1'b0, 2'd0, 13'h0B02, 32'h0, rx);
        nvm_rd_addr <= 9'h019;
        repeat (2) @(posedge core_clk);
        chk("store byte", 32'h5A, {24'h0, nvm_rd_data});
        $display("test save_done done");
        finish_test();
    end
endmodule // tb_top
`default_nettype wire
